// ==== shared/xcvr_pkg.sv ====
// Purpose: shared constants for the registered bus transceiver
// Assumes: APB register access, 32-bit data, byte addresses
// Notes: control bits live in one software register, per-section nibbles

package xcvr_pkg;

  // ==========================================================
  // structure
  localparam int SECTION_W = 8;
  localparam int SECTIONS = 2;
  localparam int BUS_W = SECTION_W * SECTIONS;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STORE_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STORE_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

  // ==========================================================
  // control field layout, one nibble per section
  localparam int CTRL_FIELD_W = 4;
  localparam int CTRL_ENABLE_N_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_A_TO_B_SEL_BIT = 2;
  localparam int CTRL_B_TO_A_SEL_BIT = 3;
  localparam int CTRL_WIDE_BIT = 8;
  localparam int CTRL_W = 9;

  // status layout: drive-a flags in low bits, drive-b flags above
  localparam int STATUS_DRIVE_A_LSB = 0;
  localparam int STATUS_DRIVE_B_LSB = 2;

  // ==========================================================
  // reset values: both sections isolated, live data selected
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h011;
  localparam logic [BUS_W-1:0] STORE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

endpackage

// ==== src/registered_bus_transceiver.sv ====
// Purpose: registered bidirectional transceiver between an A bus and a B bus
// Assumes: bus pins and register clocks come from outside sys_clk and are
//   synchronised; control comes from an APB register
// Notes: clock pins are sampled, so each pin level must stay stable for
//   at least two sys_clk periods to be seen
//   the live path lags the pins by three sys_clk edges
//   storage clears on sys_rst; the pins themselves offer no reset
//   a driven bus is seen on its own input pins and may be stored
//   wide mode copies the section 0 controls; the section 1 nibble is
//   ignored then
//
// How it works
// - two 8-bit sections; wide bit makes section 1 use section 0 controls, while each section still stores on its own clock pins
// - a_to_b_clock rise stores A into A register; b_to_a_clock rise stores B
// - capture happens on every rising clock edge, whatever enable and direction
// - either bus, or both, can be stored, each only in its own register
// - each direction's source select picks live opposite bus or stored register
// - driven outputs come from flops, so select changes cannot glitch
// - with enable low, direction picks which bus is driven
// - enable high drives neither bus; registers still capture and otherwise hold
// - enable low, direction low, b_to_a select low: A gets live B
// - enable low, direction low, b_to_a select high: A gets stored B
// - enable low, direction high, a_to_b select low: B gets live A
// - enable low, direction high, a_to_b select high: B gets stored A
// - disabled outputs leave the capture path working
// - a section never drives both buses; outside logic must not fight a driven bus
// - a lone clock edge never changes which bus is driven

`timescale 1ns/1ps

module registered_bus_transceiver
  import xcvr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [xcvr_pkg::ADDR_W-1:0] paddr,
  input wire logic [xcvr_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [xcvr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // register clock pins, one per section
  input wire logic [xcvr_pkg::SECTIONS-1:0] a_to_b_clock,
  input wire logic [xcvr_pkg::SECTIONS-1:0] b_to_a_clock,
  // a bus pins
  input wire logic [xcvr_pkg::BUS_W-1:0] a_in,
  output logic [xcvr_pkg::BUS_W-1:0] a_out,
  output logic [xcvr_pkg::BUS_W-1:0] a_oe_n,
  // b bus pins
  input wire logic [xcvr_pkg::BUS_W-1:0] b_in,
  output logic [xcvr_pkg::BUS_W-1:0] b_out,
  output logic [xcvr_pkg::BUS_W-1:0] b_oe_n
);
  import xcvr_pkg::*;

  // ==========================================================
  // helpers

  // effective control nibble of a section; wide mode slaves section 1
  function automatic logic [CTRL_FIELD_W-1:0] section_ctrl(
    input logic [CTRL_W-1:0] ctrl,
    input int sec
  );
    int src;
    src = (ctrl[CTRL_WIDE_BIT] && sec != 0) ? 0 : sec;
    return ctrl[src*CTRL_FIELD_W +: CTRL_FIELD_W];
  endfunction

  // one offset compare, shared by the read mux, the write and the error
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    return addr == off;
  endfunction

  // ==========================================================
  // pin synchronisers

  // sampled pin levels, two stages each before any logic looks at them
  logic [BUS_W-1:0] a_s1_q, a_s2_q;
  logic [BUS_W-1:0] b_s1_q, b_s2_q;
  logic [SECTIONS-1:0] cab_s1_q, cab_s2_q, cab_prev_q;
  logic [SECTIONS-1:0] cba_s1_q, cba_s2_q, cba_prev_q;
  logic [SECTIONS-1:0] cab_rise, cba_rise;

  // data and clock pins pass the same two stages, so a level that is
  // stable at the pin clock edge is the one that gets stored
  always_ff @(posedge sys_clk) begin
    a_s1_q <= a_in;
    a_s2_q <= a_s1_q;
    b_s1_q <= b_in;
    b_s2_q <= b_s1_q;
    cab_s1_q <= a_to_b_clock;
    cab_s2_q <= cab_s1_q;
    cba_s1_q <= b_to_a_clock;
    cba_s2_q <= cba_s1_q;
  end

  // the previous level follows the synchronised pin even in reset, so a
  // clock pin that is already high at release is not taken as an edge
  always_ff @(posedge sys_clk) begin
    cab_prev_q <= cab_s2_q;
    cba_prev_q <= cba_s2_q;
  end

  always_comb begin
    cab_rise = cab_s2_q & ~cab_prev_q;
    cba_rise = cba_s2_q & ~cba_prev_q;
  end

  // ==========================================================
  // control register and apb slave

  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [BUS_W-1:0] store_a_q, store_b_q;
  logic [SECTIONS-1:0] drive_a_q, drive_b_q;
  logic setup_phase, write_take, mapped;

  always_comb begin
    setup_phase = psel && !penable;
    write_take = psel && penable && pwrite;
    mapped = addr_hit(paddr, OFF_CTRL) || addr_hit(paddr, OFF_STORE_A) ||
      addr_hit(paddr, OFF_STORE_B) || addr_hit(paddr, OFF_STATUS);
  end

  // the answer is prepared in the setup cycle, so access never waits
  // and read data still comes straight from a flop
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_phase) begin
      prdata_d = RDATA_RESET;
      pslverr_d = !mapped;
      if (!pwrite) begin
        if (addr_hit(paddr, OFF_CTRL)) begin
          prdata_d[CTRL_W-1:0] = ctrl_q;
        end else if (addr_hit(paddr, OFF_STORE_A)) begin
          prdata_d[BUS_W-1:0] = store_a_q;
        end else if (addr_hit(paddr, OFF_STORE_B)) begin
          prdata_d[BUS_W-1:0] = store_b_q;
        end else if (addr_hit(paddr, OFF_STATUS)) begin
          prdata_d[STATUS_DRIVE_A_LSB +: SECTIONS] = drive_a_q;
          prdata_d[STATUS_DRIVE_B_LSB +: SECTIONS] = drive_b_q;
        end
      end
    end
  end

  // stores and status are read only, so only a control write lands;
  // byte lane 1 carries nothing but the wide bit
  always_comb begin
    ctrl_d = ctrl_q;
    if (write_take && addr_hit(paddr, OFF_CTRL)) begin
      if (pstrb[0]) begin
        ctrl_d[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        ctrl_d[CTRL_WIDE_BIT] = pwdata[CTRL_WIDE_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
      prdata_q <= RDATA_RESET;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // read data is a straight flop copy, ready is tied high and the error is gated
  always_comb begin
    pready = 1'b1;
    prdata = prdata_q;
    pslverr = pslverr_q && psel && penable;
  end

  // ==========================================================
  // transceiver sections

  logic [BUS_W-1:0] a_out_q, b_out_q, a_oe_n_q, b_oe_n_q;

  // each section hands its results over through nets, one driver per
  // slice, so that all state below is written by a single process
  wire logic [SECTIONS-1:0] drv_a_w;
  wire logic [SECTIONS-1:0] drv_b_w;
  wire logic [BUS_W-1:0] store_a_w;
  wire logic [BUS_W-1:0] store_b_w;
  wire logic [BUS_W-1:0] a_out_w;
  wire logic [BUS_W-1:0] b_out_w;

  for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
    logic [CTRL_FIELD_W-1:0] c;
    logic en_n, dir, sel_ab, sel_ba, drv_a, drv_b;
    logic [SECTION_W-1:0] sa_d, sb_d, ao_d, bo_d;

    always_comb begin
      c = section_ctrl(ctrl_q, s);
      en_n = c[CTRL_ENABLE_N_BIT];
      dir = c[CTRL_DIR_BIT];
      sel_ab = c[CTRL_A_TO_B_SEL_BIT];
      sel_ba = c[CTRL_B_TO_A_SEL_BIT];
      // only enable and direction choose the driven bus, never a clock
      drv_a = !en_n && !dir;
      drv_b = !en_n && dir;
    end

    // capture ignores enable and direction entirely
    always_comb begin
      sa_d = store_a_q[s*SECTION_W +: SECTION_W];
      sb_d = store_b_q[s*SECTION_W +: SECTION_W];
      if (cab_rise[s]) begin
        sa_d = a_s2_q[s*SECTION_W +: SECTION_W];
      end
      if (cba_rise[s]) begin
        sb_d = b_s2_q[s*SECTION_W +: SECTION_W];
      end
    end

    // the output value is registered, so a select change moves the pins
    // once at a clock edge with no decode hazard in between
    always_comb begin
      ao_d = sel_ba ? store_b_q[s*SECTION_W +: SECTION_W]
        : b_s2_q[s*SECTION_W +: SECTION_W];
      bo_d = sel_ab ? store_a_q[s*SECTION_W +: SECTION_W]
        : a_s2_q[s*SECTION_W +: SECTION_W];
    end

    assign drv_a_w[s] = drv_a;
    assign drv_b_w[s] = drv_b;
    assign store_a_w[s*SECTION_W +: SECTION_W] = sa_d;
    assign store_b_w[s*SECTION_W +: SECTION_W] = sb_d;
    assign a_out_w[s*SECTION_W +: SECTION_W] = ao_d;
    assign b_out_w[s*SECTION_W +: SECTION_W] = bo_d;
  end

  // ==========================================================
  // storage and bus output registers

  logic [BUS_W-1:0] store_a_d, store_b_d;
  logic [BUS_W-1:0] a_out_d, b_out_d;
  logic [BUS_W-1:0] a_oe_n_d, b_oe_n_d;
  logic [SECTIONS-1:0] drive_a_d, drive_b_d;

  // a store only moves on its own clock pin edge, so with both pins
  // quiet the contents hold whatever the enables do
  always_comb begin
    store_a_d = store_a_w;
    store_b_d = store_b_w;
    a_out_d = a_out_w;
    b_out_d = b_out_w;
    drive_a_d = drv_a_w;
    drive_b_d = drv_b_w;
    // all pins of one section are released or driven together
    for (int s = 0; s < SECTIONS; s++) begin
      a_oe_n_d[s*SECTION_W +: SECTION_W] = {SECTION_W{!drv_a_w[s]}};
      b_oe_n_d[s*SECTION_W +: SECTION_W] = {SECTION_W{!drv_b_w[s]}};
    end
  end

  // the enables are registered like the data, so a pin starts to be
  // driven in the same cycle as its first valid value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      store_a_q <= STORE_RESET;
      store_b_q <= STORE_RESET;
      a_out_q <= '0;
      b_out_q <= '0;
      a_oe_n_q <= '1;
      b_oe_n_q <= '1;
      drive_a_q <= '0;
      drive_b_q <= '0;
    end else begin
      store_a_q <= store_a_d;
      store_b_q <= store_b_d;
      a_out_q <= a_out_d;
      b_out_q <= b_out_d;
      a_oe_n_q <= a_oe_n_d;
      b_oe_n_q <= b_oe_n_d;
      drive_a_q <= drive_a_d;
      drive_b_q <= drive_b_d;
    end
  end

  always_comb begin
    a_out = a_out_q;
    b_out = b_out_q;
    a_oe_n = a_oe_n_q;
    b_oe_n = b_oe_n_q;
  end

endmodule

// ==== test/xcvr_checker.sv ====
// Purpose: port assertions for the transceiver
// Assumes: enables change only after a control write
// Notes: bound into every instance
`timescale 1ns/1ps
module xcvr_checker
  import xcvr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [xcvr_pkg::ADDR_W-1:0] paddr,
  input wire logic [xcvr_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [xcvr_pkg::BUS_W-1:0] a_out,
  input wire logic [xcvr_pkg::BUS_W-1:0] a_oe_n,
  input wire logic [xcvr_pkg::BUS_W-1:0] b_out,
  input wire logic [xcvr_pkg::BUS_W-1:0] b_oe_n
);
  import xcvr_pkg::*;
  // ==========================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire ctrl_wr = psel && penable && pwrite && paddr == OFF_CTRL;
  sequence apb_acc;
    psel && penable;
  endsequence
  a_never_both: assert property ((a_oe_n | b_oe_n) == 16'hffff)
    else $error("both buses driven");
  a_sect_even: assert property (a_oe_n == {{8{a_oe_n[8]}}, {8{a_oe_n[0]}}} &&
    b_oe_n == {{8{b_oe_n[8]}}, {8{b_oe_n[0]}}}) else $error("section enables split");
  a_reset_iso: assert property ($fell(sys_rst) |-> (a_oe_n & b_oe_n) == 16'hffff &&
    (a_out | b_out) == 16'h0000)
    else $error("bus driven after reset");
  // a lone pin clock must never move the enables, only a control write may
  a_oe_cause: assert property ($changed({a_oe_n, b_oe_n}) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3)) else $error("enable moved");
  a_slverr_map: assert property (apb_acc and paddr > OFF_STATUS |-> pslverr)
    else $error("unmapped access accepted");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_rdata_hold: assert property (apb_acc |=> $stable(prdata))
    else $error("read data moved");
  a_ready_acc: assert property (apb_acc |-> pready)
    else $error("no ready in access");
endmodule
bind registered_bus_transceiver xcvr_checker chk_i(.sys_clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .a_out, .a_oe_n, .b_out, .b_oe_n);

// ==== test/bus_partner.sv ====
// Purpose: far-side logic on the A and B buses
// Assumes: far side always drives where the device does not
// Notes: pin level follows the device wherever it drives
`timescale 1ns/1ps
module bus_partner
  import xcvr_pkg::*;
(
  input wire logic [xcvr_pkg::BUS_W-1:0] a_out,
  input wire logic [xcvr_pkg::BUS_W-1:0] a_oe_n,
  input wire logic [xcvr_pkg::BUS_W-1:0] b_out,
  input wire logic [xcvr_pkg::BUS_W-1:0] b_oe_n,
  input wire logic [xcvr_pkg::BUS_W-1:0] a_drv,
  input wire logic [xcvr_pkg::BUS_W-1:0] b_drv,
  output logic [xcvr_pkg::BUS_W-1:0] a_in,
  output logic [xcvr_pkg::BUS_W-1:0] b_in
);
  // ==========================================
  // yield each bit the device drives, so no pin has two drivers
  assign a_in = (a_oe_n & a_drv) | (~a_oe_n & a_out);
  assign b_in = (b_oe_n & b_drv) | (~b_oe_n & b_out);
endmodule

// ==== test/registered_bus_transceiver_bench.sv ====
// Purpose: self-checking bench for the transceiver
// Assumes: apb slave answers without wait states
// Notes: waits of 8 cycles cover the 3-edge sync path
`timescale 1ns/1ps
module registered_bus_transceiver_bench;
  import xcvr_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [SECTIONS-1:0] a_to_b_clock = 2'h0, b_to_a_clock = 2'h0;
  logic [BUS_W-1:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, a_drv = 16'h0, b_drv = 16'h0;
  int err_total = 0, n_tests = 0;
  registered_bus_transceiver DUT(.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .a_to_b_clock, .b_to_a_clock, .a_in,
    .a_out, .a_oe_n, .b_in, .b_out, .b_oe_n);
  bus_partner far(.a_out, .a_oe_n, .b_out, .b_oe_n, .a_drv, .b_drv, .a_in, .b_in);
  // ==========================================
  // shared tasks
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [1:0] ab, input logic [1:0] ba);
    @(posedge sys_clk);
    a_to_b_clock <= ab;
    b_to_a_clock <= ba;
    repeat (4) @(posedge sys_clk);
    a_to_b_clock <= 2'h0;
    b_to_a_clock <= 2'h0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic ctl(input logic [31:0] v);
    apb(1'b1, OFF_CTRL, v);
    repeat (8) @(posedge sys_clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_live();
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    a_drv <= 16'h3c5a;
    b_drv <= 16'h96e1;
    ctl(32'h002);
    chk({a_oe_n, b_oe_n}, 32'h00ffff00);
    chk(32'(b_out[7:0]), 32'h5a);
    chk(32'(a_out[15:8]), 32'h96);
  endtask
  task automatic t_store();
    ctl(32'h011);
    a_drv <= 16'h1234;
    b_drv <= 16'habcd;
    pulse(2'h3, 2'h3);
    apb(1'b0, OFF_STORE_A, 32'h0);
    chk(rd, 32'h1234);
    apb(1'b0, OFF_STORE_B, 32'h0);
    chk(rd, 32'habcd);
    a_drv <= 16'h5555;
    b_drv <= 16'haaaa;
    ctl(32'h086);
    chk(32'(b_out[7:0]), 32'h34);
    chk(32'(a_out[15:8]), 32'hab);
    ctl(32'h002);
    chk({16'h0, b_out[7:0], a_out[15:8]}, 32'h55aa);
    pulse(2'h1, 2'h0);
    chk({a_oe_n, b_oe_n}, 32'h00ffff00);
    apb(1'b1, OFF_STORE_A, 32'hffff);
    apb(1'b0, OFF_STORE_A, 32'h0);
    chk(rd, 32'h1255);
  endtask
  task automatic t_wide();
    ctl(32'h102);
    chk({b_oe_n, b_out}, 32'h00005555);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
  endtask
  task automatic conclude();
    $display("err_total %0d n_tests %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_live();
    t_store();
    t_wide();
    conclude();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
